// File: pkg/dso_regs.vh
// constants of the drive sector and port option block
// assumes a 250 MHz aclk and a 32-bit AXI4-Lite register port
`ifndef DSO_REGS_VH
`define DSO_REGS_VH

// register byte offsets
`define DSO_CTRL_OFF 8'h00
`define DSO_STATUS_OFF 8'h04
`define DSO_OPTIONS_OFF 8'h08
`define DSO_LAST_OFF 8'h0c
`define DSO_COUNT_OFF 8'h10

// control register fields and reset value
`define DSO_CTRL_SECEN_BIT 0
`define DSO_CTRL_RELEASE_BIT 1
`define DSO_CTRL_RESET 32'h00000001

// port option bank keys (key n sits at bit n-1)
`define DSO_PORT_DIS_A 0
`define DSO_PORT_DIS_B 1
`define DSO_PORT_RELTIMER 2
`define DSO_PORT_REMOTE 3
`define DSO_PORT_DELAY_LSB 4
`define DSO_PORT_DELAY_MSB 7

// service option bank keys
`define DSO_SVC_CAL 0
`define DSO_SVC_VERTICAL 2
`define DSO_SVC_INHIBIT 3

// track geometry and timing
`define DSO_TRACK_BYTES 16'd49728
`define DSO_CLK_KHZ 250000
`define DSO_RELEASE_MS 500
`define DSO_BLINK_MS 250
`define DSO_SECOND_MS 1000

// bus answers
`define DSO_RESP_OKAY 2'b00
`define DSO_RESP_SLVERR 2'b10

`endif

// File: core/dso_timer.v
// restartable countdown timer
// assumes start is a one-cycle pulse and stop a pulse or held level, both from the same clock domain
module dso_timer #(
  parameter W = 32
) (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire stop,
  input wire [W-1:0] load,
  output reg busy,
  output reg done
);
  reg [W-1:0] cnt_reg;

  // done rises load+1 cycles after start; stop wins over start
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= {W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (stop) begin
        busy <= 1'b0;
      end else if (start) begin
        cnt_reg <= load;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_reg == {W{1'b0}}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// File: core/dso_sector_counter.v
// byte-driven sector counter with index reload
// assumes byte_tick and index_in are single-cycle pulses on aclk
module dso_sector_counter (
  input wire aclk,
  input wire aresetn,
  input wire enable,
  input wire byte_tick,
  input wire index_in,
  input wire [14:0] preset,
  output reg sector_pulse,
  output reg [15:0] last_len,
  output reg [7:0] sec_count
);
  reg [14:0] cnt_reg;
  reg [15:0] bytes_reg;
  reg [7:0] in_rev_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 15'h0000;
      bytes_reg <= 16'h0000;
      in_rev_reg <= 8'h00;
      sector_pulse <= 1'b0;
      last_len <= 16'h0000;
      sec_count <= 8'h00;
    end else begin
      sector_pulse <= 1'b0;
      if (index_in) begin
        // index cuts the last sector short, never long
        cnt_reg <= preset;
        last_len <= bytes_reg;
        sec_count <= in_rev_reg + 8'h01;
        bytes_reg <= 16'h0000;
        in_rev_reg <= 8'h00;
      end else if (byte_tick) begin
        if (cnt_reg == 15'h0000) begin
          // the reload tick is the extra count of the preset
          cnt_reg <= preset;
          sector_pulse <= enable;
          in_rev_reg <= in_rev_reg + 8'h01;
          bytes_reg <= 16'h0000;
        end else begin
          cnt_reg <= cnt_reg - 15'h0001;
          bytes_reg <= bytes_reg + 16'h0001;
        end
      end
    end
  end
endmodule

// File: core/dso_options.v
// option logic of a dual-port disk drive: sectoring, spin-up, ports
// assumes switch banks are static straps sampled after reset release,
// byte_tick and index_in come from the read clock at one pulse per byte
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`include "dso_regs.vh"
module dso_options #(
  parameter CYC_PER_SEC = `DSO_SECOND_MS * `DSO_CLK_KHZ,
  parameter RELEASE_CYC = `DSO_RELEASE_MS * `DSO_CLK_KHZ,
  parameter BLINK_CYC = `DSO_BLINK_MS * `DSO_CLK_KHZ
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [6:0] sector_length_bank_low,
  input wire [6:0] sector_length_bank_high,
  input wire [3:0] service_option_bank,
  input wire [7:0] port_option_bank,
  input wire sector_mode_key,
  input wire byte_tick,
  input wire index_in,
  input wire cal_done,
  input wire pick_hold_a,
  input wire pick_hold_b,
  input wire priority_a,
  input wire priority_b,
  input wire reserve_a,
  input wire reserve_b,
  input wire release_a,
  input wire release_b,
  output reg index_out_a,
  output reg sector_out_a,
  output reg index_out_b,
  output reg sector_out_b,
  output reg reserved_a,
  output reg reserved_b,
  output reg spindle_on,
  output reg cal_seek_start,
  output reg first_status_lamp,
  output reg unit_ready,
  output reg vertical_mount,
  output reg soft_sector
);
  localparam S_SAMPLE = 3'd0;
  localparam S_SPIN = 3'd1;
  localparam S_CAL = 3'd2;
  localparam S_BLINK = 3'd3;
  localparam S_READY = 3'd4;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg sampled_reg;
  reg [6:0] len_lo_reg;
  reg [6:0] len_hi_reg;
  reg [3:0] svc_reg;
  reg [7:0] port_reg;
  reg mode_reg;
  reg [31:0] ctrl_reg;
  reg release_sw_reg;
  reg spin_wait_reg;

  wire en_a = ~port_reg[`DSO_PORT_DIS_A];
  wire en_b = ~port_reg[`DSO_PORT_DIS_B];
  wire [3:0] delay_sec =
    port_reg[`DSO_PORT_DELAY_MSB:`DSO_PORT_DELAY_LSB];
  // weight one is not a key: the bottom bit is tied high
  wire [14:0] preset = {len_hi_reg, len_lo_reg, 1'b1};
  wire [15:0] nominal = {1'b0, preset} + 16'h0001;

  // receivers of a disabled channel are ignored
  wire rx_pick = (pick_hold_a & en_a) | (pick_hold_b & en_b);
  wire rx_prio_a = priority_a & en_a;
  wire rx_prio_b = priority_b & en_b;
  wire remote = port_reg[`DSO_PORT_REMOTE];
  wire power_req = remote ? rx_pick : 1'b1;

  wire sector_pulse;
  wire [15:0] last_len;
  wire [7:0] sec_count;
  wire spin_busy;
  wire spin_done;
  wire rel_done;
  wire blink_busy;
  wire blink_done;

  dso_sector_counter u_sector (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(ctrl_reg[`DSO_CTRL_SECEN_BIT]),
    .byte_tick(byte_tick),
    .index_in(index_in),
    .preset(preset),
    .sector_pulse(sector_pulse),
    .last_len(last_len),
    .sec_count(sec_count)
  );

  // straps caught on the first clock after reset release
  always @(posedge aclk) begin
    if (!aresetn) begin
      sampled_reg <= 1'b0;
      len_lo_reg <= 7'h00;
      len_hi_reg <= 7'h00;
      svc_reg <= 4'h0;
      port_reg <= 8'h00;
      mode_reg <= 1'b0;
    end else if (!sampled_reg) begin
      sampled_reg <= 1'b1;
      len_lo_reg <= sector_length_bank_low;
      len_hi_reg <= sector_length_bank_high;
      svc_reg <= service_option_bank;
      port_reg <= port_option_bank;
      mode_reg <= sector_mode_key;
    end
  end

  // spin-up delay restarts whenever host power sequencing drops
  wire spin_start = (state_reg == S_SPIN) & power_req & ~spin_wait_reg;
  wire [31:0] spin_load = delay_sec * CYC_PER_SEC;

  dso_timer #(.W(32)) u_spin (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(spin_start),
    .stop(~power_req),
    .load(spin_load),
    .busy(spin_busy),
    .done(spin_done)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      spin_wait_reg <= 1'b0;
    end else if (!power_req || state_reg != S_SPIN) begin
      spin_wait_reg <= 1'b0;
    end else if (spin_start) begin
      spin_wait_reg <= 1'b1;
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_SAMPLE: begin
        if (sampled_reg) begin
          state_next = S_SPIN;
        end
      end
      S_SPIN: begin
        if (spin_done) begin
          state_next = svc_reg[`DSO_SVC_CAL] ? S_CAL : S_READY;
        end
      end
      S_CAL: begin
        if (!power_req) begin
          state_next = S_SPIN;
        end else if (cal_done) begin
          state_next = S_BLINK;
        end
      end
      S_BLINK: begin
        // the live key, not the strap, ends the blink
        if (!power_req) begin
          state_next = S_SPIN;
        end else if (!service_option_bank[`DSO_SVC_CAL]) begin
          state_next = S_READY;
        end
      end
      S_READY: begin
        if (!power_req) begin
          state_next = S_SPIN;
        end
      end
      default: begin
        state_next = S_SAMPLE;
      end
    endcase
  end

  wire blink_run = (state_reg == S_BLINK);
  dso_timer #(.W(32)) u_blink (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(blink_run & ~blink_busy),
    .stop(~blink_run),
    .load(BLINK_CYC[31:0]),
    .busy(blink_busy),
    .done(blink_done)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_SAMPLE;
      spindle_on <= 1'b0;
      cal_seek_start <= 1'b0;
      first_status_lamp <= 1'b0;
      unit_ready <= 1'b0;
      vertical_mount <= 1'b0;
      soft_sector <= 1'b0;
    end else begin
      state_reg <= state_next;
      spindle_on <= (state_next != S_SAMPLE) &&
        (state_next != S_SPIN);
      cal_seek_start <= (state_reg == S_SPIN) &&
        (state_next == S_CAL);
      if (state_next != S_BLINK) begin
        first_status_lamp <= 1'b0;
      end else if (blink_done) begin
        first_status_lamp <= ~first_status_lamp;
      end
      unit_ready <= (state_next == S_READY);
      vertical_mount <= svc_reg[`DSO_SVC_VERTICAL];
      soft_sector <= mode_reg;
    end
  end

  // index and sector to each channel, cut on disable or inhibit
  wire inhibit = svc_reg[`DSO_SVC_INHIBIT];
  wire pass_a = en_a & ~(inhibit & rx_prio_b);
  wire pass_b = en_b & ~(inhibit & rx_prio_a);

  always @(posedge aclk) begin
    if (!aresetn) begin
      index_out_a <= 1'b0;
      sector_out_a <= 1'b0;
      index_out_b <= 1'b0;
      sector_out_b <= 1'b0;
    end else begin
      index_out_a <= index_in & pass_a;
      sector_out_a <= sector_pulse & pass_a;
      index_out_b <= index_in & pass_b;
      sector_out_b <= sector_pulse & pass_b;
    end
  end

  // reservation: first requester holds it until release or timeout
  wire take_a = reserve_a & en_a & ~reserved_b;
  wire take_b = reserve_b & en_b & ~reserved_a & ~take_a;
  wire any_res = reserved_a | reserved_b;
  wire rel_timer_on = port_reg[`DSO_PORT_RELTIMER];
  wire host_rel = (release_a & en_a & reserved_a) |
    (release_b & en_b & reserved_b);
  wire free_res = host_rel | rel_done | release_sw_reg;

  dso_timer #(.W(32)) u_release (
    .aclk(aclk),
    .aresetn(aresetn),
    .start((take_a | take_b) & rel_timer_on),
    .stop(~rel_timer_on | host_rel | release_sw_reg),
    .load(RELEASE_CYC[31:0]),
    .busy(),
    .done(rel_done)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      reserved_a <= 1'b0;
      reserved_b <= 1'b0;
    end else if (free_res && any_res) begin
      reserved_a <= 1'b0;
      reserved_b <= 1'b0;
    end else begin
      if (take_a) begin
        reserved_a <= 1'b1;
      end
      if (take_b) begin
        reserved_b <= 1'b1;
      end
    end
  end

  // axi4-lite write: address and data taken in either order
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_held & w_held & ~s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DSO_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      ctrl_reg <= `DSO_CTRL_RESET;
      release_sw_reg <= 1'b0;
    end else begin
      release_sw_reg <= 1'b0;
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == `DSO_CTRL_OFF) begin
          s_axi_bresp <= `DSO_RESP_OKAY;
          if (w_strb_reg[0]) begin
            ctrl_reg[`DSO_CTRL_SECEN_BIT] <=
              w_data_reg[`DSO_CTRL_SECEN_BIT];
            release_sw_reg <= w_data_reg[`DSO_CTRL_RELEASE_BIT];
          end
        end else if (aw_addr_reg == `DSO_STATUS_OFF ||
            aw_addr_reg == `DSO_OPTIONS_OFF ||
            aw_addr_reg == `DSO_LAST_OFF ||
            aw_addr_reg == `DSO_COUNT_OFF) begin
          s_axi_bresp <= `DSO_RESP_OKAY;
        end else begin
          s_axi_bresp <= `DSO_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi4-lite read; shortfall is nominal length less the last sector
  reg [31:0] rd_word;
  reg rd_ok;
  wire [15:0] shortfall = nominal - last_len;
  always @* begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr[7:0])
      `DSO_CTRL_OFF: rd_word = {31'h00000000,
        ctrl_reg[`DSO_CTRL_SECEN_BIT]};
      `DSO_STATUS_OFF: rd_word = {24'h000000, state_reg,
        first_status_lamp, reserved_b, reserved_a, spindle_on,
        unit_ready};
      `DSO_OPTIONS_OFF: rd_word = {5'h00, mode_reg, svc_reg,
        port_reg, len_hi_reg, len_lo_reg};
      `DSO_LAST_OFF: rd_word = {shortfall, last_len};
      `DSO_COUNT_OFF: rd_word = {8'h00, nominal, sec_count};
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DSO_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `DSO_RESP_OKAY : `DSO_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// File: test/dso_options_props.sv
// checker for the drive option block, watching its top-level ports
// assumes straps change only while aresetn is low
module dso_options_props #(
  parameter CYC_PER_SEC = 20,
  parameter RELEASE_CYC = 10
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] service_option_bank,
  input wire [7:0] port_option_bank,
  input wire sector_mode_key,
  input wire byte_tick,
  input wire index_in,
  input wire pick_hold_a,
  input wire pick_hold_b,
  input wire priority_b,
  input wire priority_a,
  input wire reserve_a,
  input wire release_a,
  input wire index_out_a,
  input wire index_out_b,
  input wire sector_out_a,
  input wire sector_out_b,
  input wire reserved_a,
  input wire reserved_b,
  input wire spindle_on,
  input wire cal_seek_start,
  input wire unit_ready,
  input wire vertical_mount,
  input wire soft_sector
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [31:0] up_reg;
  reg [31:0] hold_reg;
  // wide counters: full-rate delays reach several billion cycles
  always @(posedge aclk) begin
    up_reg <= !aresetn ? 32'h0 : up_reg + 32'h1;
    hold_reg <= (!aresetn || !reserved_a) ? 32'h0 : hold_reg + 32'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_remote_idle;
    (port_option_bank[3] && !pick_hold_a && !pick_hold_b) [*3];
  endsequence
  sequence s_take_a;
    reserve_a && !release_a && !reserved_a && !reserved_b &&
      !port_option_bank[0];
  endsequence
  a_remote_hold: assert property (s_remote_idle |-> !spindle_on)
    else $error("spindle on without host sequence");
  a_spin_delay: assert property ($rose(spindle_on) &&
    !port_option_bank[3] |-> up_reg >= port_option_bank[7:4] * CYC_PER_SEC)
    else $error("spindle started before its delay");
  a_take_res: assert property (s_take_a |=> reserved_a)
    else $error("reservation not granted");
  a_owner_release: assert property (reserved_a && release_a |=>
    !reserved_a)
    else $error("host release ignored");
  a_timer_release: assert property (port_option_bank[2] |->
    hold_reg <= RELEASE_CYC + 2)
    else $error("reservation outlived the release timer");
  a_disabled_quiet: assert property (port_option_bank[1] |->
    !index_out_b && !sector_out_b && !reserved_b)
    else $error("disabled channel active");
  a_inhibit_b: assert property (service_option_bank[3] &&
    priority_a && !port_option_bank[0] |=> !index_out_b && !sector_out_b)
    else $error("index or sector reached non-priority channel");
  a_index_pass: assert property (index_in && !port_option_bank[0] &&
    !(service_option_bank[3] && priority_b && !port_option_bank[1])
    |=> index_out_a)
    else $error("index not forwarded");
  a_sector_cause: assert property (sector_out_a |->
    $past(byte_tick, 2))
    else $error("sector pulse without byte tick");
  a_cal_pulse: assert property (cal_seek_start |->
    service_option_bank[0] ##1 !cal_seek_start)
    else $error("calibration start wrong");
  a_ready_key: assert property (unit_ready |->
    !service_option_bank[0])
    else $error("ready with calibration key on");
  a_mount_mode: assert property ($past(aresetn, 2) |->
    vertical_mount == service_option_bank[2] &&
    soft_sector == sector_mode_key)
    else $error("mount or sector mode wrong");
endmodule

bind dso_options dso_options_props #(
  .CYC_PER_SEC(CYC_PER_SEC),
  .RELEASE_CYC(RELEASE_CYC)
) u_props (.aclk, .aresetn, .service_option_bank, .port_option_bank,
  .sector_mode_key, .byte_tick, .index_in, .pick_hold_a, .pick_hold_b,
  .priority_b, .priority_a, .reserve_a, .release_a, .index_out_a,
  .index_out_b, .sector_out_a, .sector_out_b, .reserved_a, .reserved_b,
  .spindle_on, .cal_seek_start, .unit_ready, .vertical_mount, .soft_sector);

// File: test/dso_host_model.sv
// host controller pair on the drive's interface cables
// assumes the bench calls its tasks; lines change after rising edges
module dso_host_model (
  input wire aclk,
  output logic pick_hold_a,
  output logic pick_hold_b,
  output logic priority_a,
  output logic priority_b,
  output logic reserve_a,
  output logic reserve_b,
  output logic release_a,
  output logic release_b
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {pick_hold_a, pick_hold_b, priority_a, priority_b} = 4'h0;
    {reserve_a, reserve_b, release_a, release_b} = 4'h0;
  end
  task pick(input logic ch, input logic v);
    @(posedge aclk);
    if (ch) pick_hold_b <= v;
    else pick_hold_a <= v;
  endtask
  task prio(input logic ch, input logic v);
    @(posedge aclk);
    if (ch) priority_b <= v;
    else priority_a <= v;
  endtask
  task reserve(input logic ch);
    @(posedge aclk);
    reserve_a <= !ch;
    reserve_b <= ch;
    @(posedge aclk);
    {reserve_a, reserve_b} <= 2'h0;
  endtask
  // timer off: the drive holds the unit until this command or a release write to the control register comes
  task release_res(input logic ch);
    @(posedge aclk);
    release_a <= !ch;
    release_b <= ch;
    @(posedge aclk);
    {release_a, release_b} <= 2'h0;
  endtask
endmodule

// File: test/tb_top.sv
// bench for the drive option block: straps, sectoring, spin-up, ports
// assumes the host model drives the channel lines; aclk at 250 MHz
`include "dso_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CPS = 20;
  localparam int TRK = 22;
  // length from three sectors per track: fraction dropped, one added
  localparam int SEC_LEN = TRK / 3 + 1;
  // keys hold length less one; weight one is fixed, so length is even
  localparam [6:0] LEN_LOW = (SEC_LEN - 1) >> 1;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [6:0] sector_length_bank_low = LEN_LOW;
  logic [6:0] sector_length_bank_high = '0;
  logic [3:0] service_option_bank = 4'h4;
  logic [7:0] port_option_bank = 8'h26;
  logic sector_mode_key = 1, byte_tick = 0, index_in = 0, cal_done = 0;
  wire pick_hold_a, pick_hold_b, priority_a, priority_b;
  wire reserve_a, reserve_b, release_a, release_b;
  logic index_out_a, sector_out_a, index_out_b, sector_out_b;
  logic reserved_a, reserved_b, spindle_on, cal_seek_start;
  logic first_status_lamp, unit_ready, vertical_mount, soft_sector;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  int n, ia, ib, sa, sb, cal_seen;
  dso_options #(.CYC_PER_SEC(CPS), .RELEASE_CYC(10), .BLINK_CYC(4)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sector_length_bank_low, .sector_length_bank_high,
    .service_option_bank, .port_option_bank, .sector_mode_key, .byte_tick,
    .index_in, .cal_done, .pick_hold_a, .pick_hold_b, .priority_a,
    .priority_b, .reserve_a, .reserve_b, .release_a, .release_b,
    .index_out_a, .sector_out_a, .index_out_b, .sector_out_b, .reserved_a,
    .reserved_b, .spindle_on, .cal_seek_start, .first_status_lamp,
    .unit_ready, .vertical_mount, .soft_sector);
  dso_host_model u_host (.aclk, .pick_hold_a, .pick_hold_b, .priority_a,
    .priority_b, .reserve_a, .reserve_b, .release_a, .release_b);
  always #2 aclk = ~aclk;
  // outputs stand from edge to edge, so the falling edge sees each once
  always @(negedge aclk) begin
    ia = ia + (index_out_a === 1'b1);
    ib = ib + (index_out_b === 1'b1);
    sa = sa + (sector_out_a === 1'b1);
    sb = sb + (sector_out_b === 1'b1);
    cal_seen = cal_seen | (cal_seek_start === 1'b1);
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task boot(input logic [3:0] svc, input logic [7:0] prt, input logic m);
    @(posedge aclk);
    aresetn <= 1'b0;
    service_option_bank <= svc;
    port_option_bank <= prt;
    sector_mode_key <= m;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ka, kw, kb;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    kb = 0;
    while (!kb) begin
      @(negedge aclk);
      ka = s_axi_awready && s_axi_awvalid;
      kw = s_axi_wready && s_axi_wvalid;
      kb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ka, kr;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    kr = 0;
    while (!kr) begin
      @(negedge aclk);
      ka = s_axi_arready && s_axi_arvalid;
      kr = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ka) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  // one revolution: index, then n bytes at every other cycle
  task track(input int nb);
    {ia, ib, sa, sb} = '0;
    @(posedge aclk);
    index_in <= 1'b1;
    @(posedge aclk);
    index_in <= 1'b0;
    repeat (nb) begin
      @(posedge aclk);
      byte_tick <= 1'b1;
      @(posedge aclk);
      byte_tick <= 1'b0;
    end
  endtask
  task wait_ready;
    for (n = 0; unit_ready !== 1'b1 && n < 40; n++) @(negedge aclk);
  endtask
  initial begin
    cal_seen = 0;
    boot(4'h4, 8'h26, 1'b1);
    for (n = 0; spindle_on !== 1'b1 && n < 100; n++) @(negedge aclk);
    check("spin delay", 1, n >= 2 * CPS && n <= 2 * CPS + 8);
    check("vertical", 1, vertical_mount);
    check("soft sector", 1, soft_sector);
    wait_ready();
    check("ready", 1, unit_ready);
    rd(`DSO_OPTIONS_OFF, d, r);
    check("options", {5'h0, 1'b1, 4'h4, 8'h26, 7'h0, LEN_LOW}, d);
    rd(`DSO_COUNT_OFF, d, r);
    check("nominal", SEC_LEN, d[23:8]);
    track(TRK);
    track(TRK);
    check("sectors a", TRK / SEC_LEN, sa);
    check("channel b", 0, ib + sb);
    rd(`DSO_LAST_OFF, d, r);
    check("last len", TRK - SEC_LEN * (TRK / SEC_LEN), d[15:0]);
    check("shortfall", SEC_LEN * 3 - TRK, d[31:16]);
    u_host.reserve(1'b0);
    u_host.reserve(1'b1);
    @(negedge aclk);
    check("reserved a", 1, reserved_a);
    check("reserved b", 0, reserved_b);
    repeat (12) @(negedge aclk);
    check("timer release", 0, reserved_a);
    u_host.reserve(1'b0);
    wr(`DSO_CTRL_OFF, 32'h3, r);
    @(negedge aclk);
    check("forced release", 0, reserved_a);
    check("ctrl resp", `DSO_RESP_OKAY, r);
    wr(`DSO_STATUS_OFF, 32'h0, r);
    check("ro write", `DSO_RESP_OKAY, r);
    wr(8'h40, 32'h0, r);
    check("bad write", `DSO_RESP_SLVERR, r);
    rd(8'h40, d, r);
    check("bad read", `DSO_RESP_SLVERR, r);
    check("bad read data", 32'h0, d);
    rd(`DSO_STATUS_OFF, d, r);
    check("status", 32'h3, d & 32'h3);
    s_axi_wstrb <= 4'h0;
    wr(`DSO_CTRL_OFF, 32'h0, r);
    s_axi_wstrb <= 4'hf;
    rd(`DSO_CTRL_OFF, d, r);
    check("strobe off", 1, d);
    wr(`DSO_CTRL_OFF, 32'h0, r);
    track(TRK);
    check("sector off", 0, sa);
    {sector_length_bank_high, sector_length_bank_low} <= 14'h0080;
    boot(4'h9, 8'h08, 1'b0);
    repeat (30) @(negedge aclk);
    check("remote hold", 0, spindle_on);
    check("horizontal", 0, vertical_mount);
    check("hard sector", 0, soft_sector);
    rd(`DSO_COUNT_OFF, d, r);
    check("nominal high", 258, d[23:8]);
    u_host.pick(1'b1, 1'b1);
    for (n = 0; spindle_on !== 1'b1 && n < 20; n++) @(negedge aclk);
    check("remote spin", 1, spindle_on);
    repeat (3) @(negedge aclk);
    check("cal start", 1, cal_seen);
    check("not ready", 0, unit_ready);
    u_host.prio(1'b0, 1'b1);
    track(TRK);
    track(TRK);
    check("index a", 1, ia);
    check("inhibited b", 0, ib + sb);
    u_host.prio(1'b0, 1'b0);
    u_host.prio(1'b1, 1'b1);
    track(TRK);
    check("inhibited a", 0, ia + sa);
    check("index b", 1, ib);
    u_host.reserve(1'b0);
    repeat (20) @(negedge aclk);
    check("held", 1, reserved_a);
    u_host.reserve(1'b1);
    @(negedge aclk);
    check("first wins", 0, reserved_b);
    u_host.release_res(1'b0);
    @(negedge aclk);
    check("host release", 0, reserved_a);
    u_host.reserve(1'b1);
    @(negedge aclk);
    check("held b", 1, reserved_b);
    u_host.release_res(1'b1);
    @(negedge aclk);
    check("host release b", 0, reserved_b);
    @(posedge aclk);
    cal_done <= 1'b1;
    @(posedge aclk);
    cal_done <= 1'b0;
    for (n = 0; first_status_lamp !== 1'b1 && n < 20; n++) @(negedge aclk);
    check("lamp", 1, first_status_lamp);
    check("wait key", 0, unit_ready);
    @(posedge aclk);
    service_option_bank <= 4'h8;
    wait_ready();
    check("cal ready", 1, unit_ready);
    tally_and_finish();
  end
endmodule
